// >>> verilog/wts_pkg.sv
// Package of register offsets, field positions and reset values for the synth register bank
package wts_pkg;
   // Register indices (printed offsets are not all multiples of four: byte address is index * 4)
   localparam logic [7:0] IDX_DAC_HIGH   = 8'h1D;
   localparam logic [7:0] IDX_DAC_LOW    = 8'h1E;
   localparam logic [7:0] IDX_CONV_CTRL  = 8'h1F;
   localparam logic [7:0] IDX_VOICE_SEL  = 8'h20;
   localparam logic [7:0] IDX_PITCH_HI   = 8'h21;
   localparam logic [7:0] IDX_PITCH_LO   = 8'h22;
   localparam logic [7:0] IDX_BASE_HI    = 8'h23;
   localparam logic [7:0] IDX_BASE_LO    = 8'h24;
   localparam logic [7:0] IDX_LOOP_HI    = 8'h25;
   localparam logic [7:0] IDX_LOOP_LO    = 8'h26;
   localparam logic [7:0] IDX_ENV_VOL    = 8'h27;
   localparam logic [7:0] IDX_RSVD       = 8'h28;
   localparam logic [7:0] IDX_LVOL_LO    = 8'h29;
   localparam logic [7:0] IDX_RVOL_LO    = 8'h2A;
   localparam logic [7:0] IDX_FIRST      = 8'h1D;
   localparam logic [7:0] IDX_LAST       = 8'h2F;
   localparam int         ADDR_W         = 10;
   // Converter control bits
   localparam int BIT_SRC_RIGHT = 0;
   localparam int BIT_DAC_POWER = 1;
   localparam int BIT_SRC_LEFT  = 2;
   localparam logic [7:0] CONV_CTRL_MASK = 8'h07;
   localparam logic [7:0] CONV_CTRL_RST  = 8'h00;
   // Voice select bits
   localparam int BIT_VOLUME_ONLY = 7;
   localparam int BIT_PITCH_ONLY  = 6;
   localparam logic [7:0] VOICE_SEL_MASK = 8'hC7;
   localparam logic [7:0] VOICE_SEL_RST  = 8'h00;
   // Field masks of partially used registers
   localparam logic [7:0] BASE_HI_MASK = 8'h0F;
   localparam logic [7:0] ENV_VOL_MASK = 8'hBF;
   localparam int BIT_ENV_DIR = 7;
   // Wave data and bus response codes
   localparam logic [7:0] END_OF_WAVE  = 8'h80;
   localparam int         FETCH_W      = 17;
   localparam int         FETCH_LSB0   = 5;
   localparam logic [1:0] BRESP_OKAY   = 2'b00;
   localparam logic [1:0] BRESP_SLVERR = 2'b10;
endpackage

// >>> verilog/wts_voice_if.sv
// Interface carrying one voice-parameter launch from register bank to voice buffer
`timescale 1ns/10ps
interface wts_voice_if;
   logic        valid;
   logic        ready;
   logic [2:0]  voice;
   logic [1:0]  mode;
   logic [15:0] pitch;
   logic [11:0] base;
   logic [15:0] widthLoop;
   logic [7:0]  envVol;
   logic [7:0]  lvol;
   logic [7:0]  rvol;
   modport src  (output valid, voice, mode, pitch, base, widthLoop, envVol, lvol, rvol,
                 input ready);
   modport sink (input valid, voice, mode, pitch, base, widthLoop, envVol, lvol, rvol,
                 output ready);
endinterface

// >>> verilog/wts_launch_buf.sv
// Two-entry skid buffer holding voice launch commands toward the synth engine
`timescale 1ns/10ps
module wts_launch_buf #(
   parameter int WIDTH = 73
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   // Fill side
   wts_voice_if.sink             inPort,
   // Drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   if (WIDTH != 73) begin : g_bad_width
      $error("WIDTH must match launch word");
   end

   logic [WIDTH-1:0] mem_r [2];
   logic             wrPtr_r;
   logic             rdPtr_r;
   logic [1:0]       count_r;
   logic [WIDTH-1:0] inWord;
   logic             push;
   logic             pop;

   assign inWord = {inPort.voice, inPort.mode, inPort.pitch, inPort.base,
                    inPort.widthLoop, inPort.envVol, inPort.lvol, inPort.rvol};
   assign inPort.ready = (count_r != 2'h2);
   assign outValid     = (count_r != 2'h0);
   assign push = inPort.valid && inPort.ready;
   assign pop  = outValid && outReady;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_r[wrPtr_r] <= inWord;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wrPtr_r <= 1'b0;
         rdPtr_r <= 1'b0;
         count_r <= 2'h0;
      end else begin
         if (push) begin
            wrPtr_r <= ~wrPtr_r;
         end
         if (pop) begin
            rdPtr_r <= ~rdPtr_r;
         end
         count_r <= count_r + {1'b0, push} - {1'b0, pop};
      end
   end

   // Head must be right in the cycle outValid rises, so a push into an empty head bypasses mem_r
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         outData <= '0;
      end else if (push && (count_r == 2'h0 || (count_r == 2'h1 && pop))) begin
         outData <= inWord;
      end else if (pop && count_r == 2'h2) begin
         outData <= mem_r[~rdPtr_r];
      end
   end
endmodule

// >>> verilog/wts_regs.sv
// AXI4-Lite register bank of the eight-voice wavetable synthesizer and its DAC
//
// Summary of operation
// - 16-bit DAC sample in two unreset bytes
// - Power bit 1, reset off
// - Source select: bit2 left, bit0 right
// - Low three bits pick voice
// - Voice-select write launches playback
// - Bits 7/6 choose volume or pitch update
// - Octave nibble plus 12-bit pitch step
// - 12-bit wave base, upper nibble unused
// - Bit7 width select, 15-bit loop offset
// - Unused bits and slots read zero
// - Width bit: 8-bit or packed 12-bit
// - Attenuation zero loudest, all ones quietest
// - Base drives fetch bits 16..5, rest zero
// - Sample byte 80H ends the wave
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module wts_regs (
   // Clock and reset
   input  wire logic          core_clk,
   input  wire logic          sys_rst,
   // AXI4-Lite write address
   input  wire logic [9:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [9:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   // DAC
   output logic [15:0]        dacSampleWord,
   output logic               dacPower,
   output logic               dacSourceLeft,
   output logic               dacSourceRight,
   // Voice launch toward the engine
   output logic               launchValid,
   input  wire logic          launchReady,
   output logic [2:0]         launchVoice,
   output logic               launchPitchOnly,
   output logic               launchVolumeOnly,
   output logic [3:0]         pitchOctaveShift,
   output logic [11:0]        pitchStep,
   output logic [16:0]        waveFetchBase,
   output logic               sampleWidth12,
   output logic [14:0]        loopOffset,
   output logic               envelopeDirection,
   output logic [1:0]         envelopeSpan,
   output logic [9:0]         leftAttenuation,
   output logic [9:0]         rightAttenuation,
   // Wave end detection on fetched bytes
   input  wire logic [7:0]    fetchedByte,
   input  wire logic          fetchedValid,
   output logic               waveEnd
);
   // ==========================================================
   // Register storage
   logic [7:0] dacHigh_r;
   logic [7:0] dacLow_r;
   logic [7:0] convCtrl_r;
   logic [7:0] voiceSel_r;
   logic [7:0] pitchHi_r;
   logic [7:0] pitchLo_r;
   logic [7:0] baseHi_r;
   logic [7:0] baseLo_r;
   logic [7:0] loopHi_r;
   logic [7:0] loopLo_r;
   logic [7:0] envVol_r;
   logic [7:0] lvolLo_r;
   logic [7:0] rvolLo_r;

   // ==========================================================
   // Write channel
   logic [9:0]  awAddr_r;
   logic        awHeld_r;
   logic [31:0] wData_r;
   logic        wStrb0_r;
   logic        wHeld_r;
   logic        bvalid_r;
   logic        bErr_r;
   logic        doWrite;
   logic [7:0]  wrIdx;
   logic        wrHit;
   logic        launchPending_r;
   logic        launchStall;

   // A launch still waiting in front of a full buffer holds off further writes
   assign launchStall   = launchPending_r;
   assign s_axi_awready = !awHeld_r && !bvalid_r;
   assign s_axi_wready  = !wHeld_r && !bvalid_r;
   assign doWrite       = awHeld_r && wHeld_r && !bvalid_r && !launchStall;
   assign wrIdx         = awAddr_r[9:2];
   assign wrHit         = (awAddr_r[1:0] == 2'b00) && (wrIdx >= wts_pkg::IDX_FIRST)
                          && (wrIdx <= wts_pkg::IDX_LAST);
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bErr_r ? wts_pkg::BRESP_SLVERR : wts_pkg::BRESP_OKAY;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         awHeld_r <= 1'b0;
         awAddr_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_r <= 1'b1;
         awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
         awHeld_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wHeld_r  <= 1'b0;
         wData_r  <= '0;
         wStrb0_r <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_r  <= 1'b1;
         wData_r  <= s_axi_wdata;
         wStrb0_r <= s_axi_wstrb[0];
      end else if (doWrite) begin
         wHeld_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         bvalid_r <= 1'b0;
         bErr_r   <= 1'b0;
      end else if (doWrite) begin
         bvalid_r <= 1'b1;
         bErr_r   <= !wrHit;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ==========================================================
   // Register updates; only byte lane 0 carries data
   logic       wrEn;
   logic [7:0] wb;
   assign wrEn = doWrite && wrHit && wStrb0_r;
   assign wb   = wData_r[7:0];

   always_ff @(posedge core_clk) begin
      if (wrEn && wrIdx == wts_pkg::IDX_DAC_HIGH) begin
         dacHigh_r <= wb;
      end
      if (wrEn && wrIdx == wts_pkg::IDX_DAC_LOW) begin
         dacLow_r <= wb;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         convCtrl_r <= wts_pkg::CONV_CTRL_RST;
      end else if (wrEn && wrIdx == wts_pkg::IDX_CONV_CTRL) begin
         convCtrl_r <= wb & wts_pkg::CONV_CTRL_MASK;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         voiceSel_r <= wts_pkg::VOICE_SEL_RST;
      end else if (wrEn && wrIdx == wts_pkg::IDX_VOICE_SEL) begin
         voiceSel_r <= wb & wts_pkg::VOICE_SEL_MASK;
      end
   end

   always_ff @(posedge core_clk) begin
      if (wrEn) begin
         case (wrIdx)
            wts_pkg::IDX_PITCH_HI: begin
               pitchHi_r <= wb;
            end
            wts_pkg::IDX_PITCH_LO: begin
               pitchLo_r <= wb;
            end
            wts_pkg::IDX_BASE_HI: begin
               baseHi_r <= wb & wts_pkg::BASE_HI_MASK;
            end
            wts_pkg::IDX_BASE_LO: begin
               baseLo_r <= wb;
            end
            wts_pkg::IDX_LOOP_HI: begin
               loopHi_r <= wb;
            end
            wts_pkg::IDX_LOOP_LO: begin
               loopLo_r <= wb;
            end
            wts_pkg::IDX_ENV_VOL: begin
               envVol_r <= wb & wts_pkg::ENV_VOL_MASK;
            end
            wts_pkg::IDX_LVOL_LO: begin
               lvolLo_r <= wb;
            end
            wts_pkg::IDX_RVOL_LO: begin
               rvolLo_r <= wb;
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // Launch path through the two-entry buffer
   wts_voice_if launchIf ();
   logic [72:0] launchWord;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         launchPending_r <= 1'b0;
      end else if (wrEn && wrIdx == wts_pkg::IDX_VOICE_SEL) begin
         launchPending_r <= 1'b1;
      end else if (launchIf.ready) begin
         launchPending_r <= 1'b0;
      end
   end

   // Snapshot taken at launch relies on parameters written beforehand
   assign launchIf.valid     = launchPending_r;
   assign launchIf.voice     = voiceSel_r[2:0];
   assign launchIf.mode      = {voiceSel_r[wts_pkg::BIT_VOLUME_ONLY],
                                voiceSel_r[wts_pkg::BIT_PITCH_ONLY]};
   assign launchIf.pitch     = {pitchHi_r, pitchLo_r};
   assign launchIf.base      = {baseHi_r[3:0], baseLo_r};
   assign launchIf.widthLoop = {loopHi_r, loopLo_r};
   assign launchIf.envVol    = envVol_r;
   assign launchIf.lvol      = lvolLo_r;
   assign launchIf.rvol      = rvolLo_r;

   wts_launch_buf #(
      .WIDTH (73)
   ) launchBuf (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .inPort   (launchIf),
      .outValid (launchValid),
      .outReady (launchReady),
      .outData  (launchWord)
   );

   // Mode bits travel with the launch
   assign launchVoice      = launchWord[72:70];
   assign launchVolumeOnly = launchWord[69];
   assign launchPitchOnly  = launchWord[68];
   assign pitchOctaveShift = launchWord[67:64];
   assign pitchStep        = launchWord[63:52];
   assign waveFetchBase    = {launchWord[51:40], 5'h00};
   assign sampleWidth12    = launchWord[39];
   assign loopOffset       = launchWord[38:24];
   // Envelope and attenuation fields, passed unaltered
   assign envelopeDirection = launchWord[23];
   assign leftAttenuation   = {launchWord[21:20], launchWord[15:8]};
   assign envelopeSpan      = launchWord[19:18];
   assign rightAttenuation  = {launchWord[17:16], launchWord[7:0]};

   // DAC outputs straight from their registers
   assign dacSampleWord  = {dacHigh_r, dacLow_r};
   assign dacPower       = convCtrl_r[wts_pkg::BIT_DAC_POWER];
   assign dacSourceLeft  = convCtrl_r[wts_pkg::BIT_SRC_LEFT];
   assign dacSourceRight = convCtrl_r[wts_pkg::BIT_SRC_RIGHT];

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         waveEnd <= 1'b0;
      end else begin
         waveEnd <= fetchedValid && (fetchedByte == wts_pkg::END_OF_WAVE);
      end
   end

   // ==========================================================
   // Read channel
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic        rErr_r;
   logic [7:0]  rdIdx;
   logic        rdHit;
   logic [7:0]  rdByte;

   assign s_axi_arready = !rvalid_r;
   assign rdIdx = s_axi_araddr[9:2];
   assign rdHit = (s_axi_araddr[1:0] == 2'b00) && (rdIdx >= wts_pkg::IDX_FIRST)
                  && (rdIdx <= wts_pkg::IDX_LAST);

   // Unused slots and bits read zero
   always_comb begin
      rdByte = 8'h00;
      case (rdIdx)
         wts_pkg::IDX_DAC_HIGH:  rdByte = dacHigh_r;
         wts_pkg::IDX_DAC_LOW:   rdByte = dacLow_r;
         wts_pkg::IDX_CONV_CTRL: rdByte = convCtrl_r;
         wts_pkg::IDX_VOICE_SEL: rdByte = voiceSel_r;
         wts_pkg::IDX_PITCH_HI:  rdByte = pitchHi_r;
         wts_pkg::IDX_PITCH_LO:  rdByte = pitchLo_r;
         wts_pkg::IDX_BASE_HI:   rdByte = baseHi_r;
         wts_pkg::IDX_BASE_LO:   rdByte = baseLo_r;
         wts_pkg::IDX_LOOP_HI:   rdByte = loopHi_r;
         wts_pkg::IDX_LOOP_LO:   rdByte = loopLo_r;
         wts_pkg::IDX_ENV_VOL:   rdByte = envVol_r;
         wts_pkg::IDX_LVOL_LO:   rdByte = lvolLo_r;
         wts_pkg::IDX_RVOL_LO:   rdByte = rvolLo_r;
         default:                rdByte = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rErr_r   <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rdata_r  <= {24'h000000, rdHit ? rdByte : 8'h00};
         rErr_r   <= !rdHit;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata  = rdata_r;
   assign s_axi_rresp  = rErr_r ? wts_pkg::BRESP_SLVERR : wts_pkg::BRESP_OKAY;
endmodule

// >>> testbench/wts_regs_props.sv
// Assertion checker bound to the synth register bank ports
`timescale 1ns/10ps
module wts_regs_props (
   // Clock and reset
   input logic        core_clk,
   input logic        sys_rst,
   // Register bus
   input logic [9:0]  s_axi_awaddr,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic [3:0]  s_axi_wstrb,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic        s_axi_bvalid,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic        s_axi_rvalid,
   // Synth side
   input logic        dacPower,
   input logic        launchValid,
   input logic        launchReady,
   input logic [2:0]  launchVoice,
   input logic [11:0] pitchStep,
   input logic [16:0] waveFetchBase,
   input logic [14:0] loopOffset,
   input logic [7:0]  fetchedByte,
   input logic        fetchedValid,
   input logic        waveEnd
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // ==========================================
   // Sequences
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_sel_write;
      s_wr_take ##0 (s_axi_awaddr == {wts_pkg::IDX_VOICE_SEL, 2'b00} && s_axi_wstrb[0]);
   endsequence
   sequence s_end_byte;
      fetchedValid && fetchedByte == 8'h80;
   endsequence

   // ==========================================
   // Properties
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000
   ) else $error("read answer late or upper bits set");
   // A stalled launch may delay the response, so only the free case is timed
   a_write_answer: assert property (
      s_wr_take ##0 !launchValid |-> ##[1:2] s_axi_bvalid
   ) else $error("write response late");
   a_launch_follow: assert property (
      s_sel_write |-> ##[1:30] launchValid
   ) else $error("voice select did not launch");
   a_launch_hold: assert property (
      launchValid && !launchReady |=> launchValid &&
         $stable({launchVoice, pitchStep, waveFetchBase, loopOffset})
   ) else $error("launch dropped or changed while stalled");
   a_fetch_align: assert property (
      launchValid |-> waveFetchBase[4:0] == 5'h00
   ) else $error("fetch base not 32-byte aligned");
   a_end_pulse: assert property (
      s_end_byte |=> waveEnd
   ) else $error("end marker missed");
   a_end_quiet: assert property (
      !(fetchedValid && fetchedByte == 8'h80) |=> !waveEnd
   ) else $error("false wave end");
   a_dac_reset: assert property (
      $fell(sys_rst) |-> !dacPower
   ) else $error("converter on after reset");
endmodule

bind wts_regs wts_regs_props u_props (
   .core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wstrb,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .dacPower, .launchValid, .launchReady, .launchVoice,
   .pitchStep, .waveFetchBase, .loopOffset, .fetchedByte, .fetchedValid, .waveEnd
);

// >>> testbench/wts_engine_model.sv
// Far-side engine model: launch consumer and wave byte source
`timescale 1ns/10ps
module wts_engine_model (
   // Clock and reset
   input  logic       core_clk,
   input  logic       sys_rst,
   // Test control
   input  logic       stall,
   // Launch stream
   output logic       launchReady,
   // Wave fetch
   output logic [7:0] fetchedByte,
   output logic       fetchedValid
);
   integer      seed = 32'hd08E;
   logic [31:0] rnd;

   // ==========================================
   // Ready is withheld at random so the buffer must hold words
   always @(posedge core_clk) begin
      rnd = $random(seed);
      launchReady <= !sys_rst && !stall && rnd[1:0] != 2'b00;
      fetchedValid <= !sys_rst && rnd[2];
      fetchedByte <= (rnd[6:4] == 3'h0) ? 8'h80 : rnd[15:8];
   end
endmodule

// >>> testbench/wts_regs_tb_top.sv
// Self-checking bench for the synth register bank
`timescale 1ns/10ps
module wts_regs_tb_top;
   logic        core_clk, sys_rst, stall;
   logic [9:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, dacPower, dacSourceLeft, dacSourceRight;
   logic        launchValid, launchReady, launchPitchOnly, launchVolumeOnly;
   logic        sampleWidth12, envelopeDirection, fetchedValid, waveEnd;
   logic [15:0] dacSampleWord;
   logic [2:0]  launchVoice;
   logic [3:0]  pitchOctaveShift;
   logic [11:0] pitchStep;
   logic [16:0] waveFetchBase;
   logic [14:0] loopOffset;
   logic [1:0]  envelopeSpan;
   logic [9:0]  leftAttenuation, rightAttenuation;
   logic [7:0]  fetchedByte, d1, d2, d3;
   integer      seed = 32'hd08E;
   int          bad_count = 0;
   int          num_checks = 0;
   logic [7:0]  sh [8'h1D:8'h2F];
   logic [76:0] expq [$];

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   wts_regs dut (
      .core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .dacSampleWord, .dacPower, .dacSourceLeft,
      .dacSourceRight, .launchValid, .launchReady, .launchVoice, .launchPitchOnly,
      .launchVolumeOnly, .pitchOctaveShift, .pitchStep, .waveFetchBase, .sampleWidth12,
      .loopOffset, .envelopeDirection, .envelopeSpan, .leftAttenuation, .rightAttenuation,
      .fetchedByte, .fetchedValid, .waveEnd
   );
   wts_engine_model u_eng (.core_clk, .sys_rst, .stall, .launchReady, .fetchedByte,
                           .fetchedValid);

   // ==========================================
   // Expectations
   function automatic logic [7:0] msk(input logic [7:0] i);
      case (i)
         8'h1F: msk = 8'h07;
         8'h20: msk = 8'hC7;
         8'h23: msk = 8'h0F;
         8'h27: msk = 8'hBF;
         8'h28, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F: msk = 8'h00;
         default: msk = 8'hFF;
      endcase
   endfunction

   function automatic logic [76:0] exp_launch();
      exp_launch = {sh[8'h20][2:0], sh[8'h20][7:6], sh[8'h21], sh[8'h22], sh[8'h23][3:0],
                    sh[8'h24], 5'h00, sh[8'h25], sh[8'h26], sh[8'h27][7], sh[8'h27][3:2],
                    sh[8'h27][5:4], sh[8'h29], sh[8'h27][1:0], sh[8'h2A]};
   endfunction

   task chk(input logic [79:0] seen, input logic [79:0] want);
      num_checks++;
      if (seen !== want) begin
         bad_count++;
         $display("wrong value at %0t: seen %0h want %0h", $time, seen, want);
      end
   endtask

   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ==========================================
   // Bus master; ready and answers are judged just after an edge, taken at the next
   task wr(input logic [9:0] a, input logic [7:0] d);
      logic ta, tw, tb;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
         #1;
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge core_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask

   task rd(input logic [9:0] a);
      logic ta, tr;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      tr = 1'b0;
      while (!tr) begin
         #1;
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         rdv = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge core_clk);
         if (ta) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask

   task wreg(input logic [7:0] i, input logic [7:0] d);
      sh[i] = d & msk(i);
      if (i == 8'h20) expq.push_back(exp_launch());
      wr({i, 2'b00}, d);
      chk(rsp, 2'b00);
   endtask

   // Every launch taken by the engine must match the oldest expected snapshot
   always begin
      @(posedge core_clk);
      #1;
      if (launchValid === 1'b1 && launchReady === 1'b1) begin
         if (expq.size() == 0)
            chk(1'b1, 1'b0);
         else
            chk({launchVoice, launchVolumeOnly, launchPitchOnly, pitchOctaveShift, pitchStep,
                 waveFetchBase, sampleWidth12, loopOffset, envelopeDirection, envelopeSpan,
                 leftAttenuation, rightAttenuation},
                expq.pop_front());
      end
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      end_sim;
   end

   // ==========================================
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      stall = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 10'h000;
      s_axi_araddr = 10'h000;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'h0;
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd({8'h1F, 2'b00});
      chk(rdv, 32'h00000000);
      rd({8'h20, 2'b00});
      chk(rdv, 32'h00000000);
      $display("reset test done");
      // Descending so parameters precede the voice select write
      for (int i = 8'h2F; i >= 8'h1D; i--) begin
         wreg(i[7:0], 8'($random(seed)));
         rd({i[7:0], 2'b00});
         chk(rdv, {24'h000000, sh[i[7:0]]});
      end
      $display("register table test done");
      for (int m = 0; m < 4; m++) begin
         for (int i = 8'h21; i <= 8'h2A; i++) wreg(i[7:0], 8'($random(seed)));
         wreg(8'h20, {m[1:0], 3'b000, 3'($random(seed))});
      end
      $display("update mode test done");
      repeat (4) begin
         d1 = 8'($random(seed));
         d2 = 8'($random(seed));
         d3 = 8'($random(seed));
         wreg(8'h1D, d1);
         wreg(8'h1E, d2);
         wreg(8'h1F, d3);
         #1 chk({dacSampleWord, dacSourceLeft, dacPower, dacSourceRight},
                {d1, d2, d3[2:0]});
      end
      $display("converter test done");
      wr(10'h100, 8'h5A);
      chk(rsp, 2'b10);
      wr(10'h081, 8'h5A);
      chk(rsp, 2'b10);
      rd(10'h3FC);
      chk({rsp, rdv}, {2'b10, 32'h00000000});
      rd({8'h20, 2'b00});
      chk(rdv, {24'h000000, sh[8'h20]});
      $display("error test done");
      // Two words fill the buffer, a third waits, the fourth write must be held off
      stall <= 1'b1;
      repeat (3) @(posedge core_clk);
      for (int k = 0; k < 3; k++) wreg(8'h20, 8'(k));
      fork
         wreg(8'h20, 8'h07);
         begin
            repeat (20) @(posedge core_clk);
            #1 chk(s_axi_bvalid, 1'b0);
            stall <= 1'b0;
         end
      join
      repeat (20) @(posedge core_clk);
      chk(expq.size(), 0);
      $display("buffer test done");
      end_sim;
   end
endmodule
